//--- sw_pkg.sv
package sw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_ON_VAL = 12'h004;
  localparam logic [11:0] ADDR_OFF_VAL = 12'h008;
  localparam logic [11:0] ADDR_ON_DLY = 12'h00C;
  localparam logic [11:0] ADDR_OFF_DLY = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int FUNC_LSB = 0;
  localparam int DIAG_LSB = 4;
  localparam int SRC_LSB = 8;
  localparam int VAR_LSB = 12;
  localparam int FAIL_LSB = 16;
  localparam int INV_BIT = 20;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0013_F737;

  // Switch function codes.
  localparam logic [2:0] FUNC_OFF = 3'h0;
  localparam logic [2:0] FUNC_ON = 3'h1;
  localparam logic [2:0] FUNC_DIAG = 3'h2;
  localparam logic [2:0] FUNC_LIMIT = 3'h3;
  localparam logic [2:0] FUNC_DOUT = 3'h4;

  // Diagnostic event selection.
  localparam logic [1:0] DIAG_ALARM = 2'h0;
  localparam logic [1:0] DIAG_ALARM_WARN = 2'h1;
  localparam logic [1:0] DIAG_WARN = 2'h2;

  // Discrete source selection.
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_AD1 = 3'h1;
  localparam logic [2:0] SRC_AD2 = 3'h2;
  localparam logic [2:0] SRC_DO1 = 3'h3;
  localparam logic [2:0] SRC_DO2 = 3'h4;
  localparam logic [2:0] SRC_DO3 = 3'h5;
  localparam logic [2:0] SRC_DO4 = 3'h6;

  // Failure behaviour.
  localparam logic [1:0] FAIL_ACTUAL = 2'h0;
  localparam logic [1:0] FAIL_OPEN = 2'h1;
  localparam logic [1:0] FAIL_CLOSED = 2'h2;

  // Status register bits.
  localparam int ST_CLOSED = 0;
  localparam int ST_DELAYED = 1;
  localparam int ST_LIMIT = 2;
  localparam int ST_WARN = 3;
  localparam int ST_ALARM = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DLY_W = 10;
  localparam logic [9:0] DLY_MAX = 10'h3E8;
  localparam longint CLK_PERIOD_NS = 50;
  localparam longint DLY_STEP_NS = 100000000;
  localparam int STEP_CYCLES = int'((DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

//--- dly_if.sv
// Carries the limit state and delay settings to the delay timer.
interface dly_if #(
  parameter int DLY_W = 10
);
  logic target;
  logic [DLY_W-1:0] on_dly;
  logic [DLY_W-1:0] off_dly;
  logic state;
  modport ctrl (output target, output on_dly, output off_dly, input state);
  modport timer (input target, input on_dly, input off_dly, output state);
endinterface

//--- switch_delay.sv
// Applies the switch-on and switch-off delays to the limit state.
module switch_delay #(
  parameter int STEP_CYCLES = sw_pkg::STEP_CYCLES,
  parameter int DLY_W = sw_pkg::DLY_W
) (
  input wire logic pclk,    // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  dly_if.timer dl           // Limit state in, delayed state out.
);

  logic [31:0] pre_q;
  logic [DLY_W-1:0] count_q;
  logic state_q;

  if (STEP_CYCLES < 1) $error("STEP_CYCLES must be at least one");

  // A change is pending while the delayed state differs from the target.
  wire pending = dl.target != state_q;
  wire [DLY_W-1:0] limit = dl.target ? dl.on_dly : dl.off_dly;
  wire expire = pending && (count_q >= limit);
  wire tick = pre_q == 32'(STEP_CYCLES - 1);

  assign dl.state = state_q;

  // The prescaler restarts whenever no change is pending, so each delay that starts from a settled state is exact.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 32'h0000_0000;
      count_q <= '0;
      state_q <= 1'b0;
    end else begin
      pre_q <= (!pending || tick) ? 32'h0000_0000 : pre_q + 32'h0000_0001;
      count_q <= (!pending || expire) ? '0 : count_q + DLY_W'(tick);
      state_q <= expire ? dl.target : state_q;
    end
  end

  AST_DLY_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    pending && count_q < limit |=> $stable(state_q))
    else $error("Delayed state changed before its delay ran out");
  AST_DLY_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pending && limit == '0 |=> state_q == $past(dl.target))
    else $error("Zero delay did not pass the state at once");

endmodule

//--- switch_output_controller.sv
// ----------------------------------------------------------------
// Switch output controller
// ----------------------------------------------------------------
// Overview of operation
// - Off function keeps output always open.
// - On function keeps output always closed.
// - Off and On force output, simulating it.
// - Diagnostic mode: closed, opens on event.
// - Diagnostic selector: alarm, either, or warning.
// - On above off: close above, open below.
// - On below off: close below, open above.
// - Switch-on delay 0 to 100 s, 0.1 s.
// - Separate switch-off delay up to 100 s.
// - Discrete mode follows chosen block output.
// - Source: none, two diagnostic, four general.
// - Alarm in limit/discrete applies failure setting.
// - Present switch state readable by software.
// - Invert option No or Yes provided.
// - Invert Yes swaps open and closed everywhere.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
module switch_output_controller #(
  parameter int STEP_CYCLES = sw_pkg::STEP_CYCLES,
  parameter int NUM_VARS = 12,
  parameter int MEAS_W = 32
) (
  input wire logic pclk,                            // Bus and system clock.
  input wire logic presetn,                         // Asynchronous reset, active low.
  input wire logic psel,                            // APB select.
  input wire logic penable,                         // APB enable.
  input wire logic pwrite,                          // APB direction, high for write.
  input wire logic [sw_pkg::ADDR_W-1:0] paddr,      // APB byte address.
  input wire logic [31:0] pwdata,                   // APB write data.
  output logic [31:0] prdata,                       // APB read data.
  output logic pready,                              // APB ready.
  output logic pslverr,                             // APB error for unmapped address.
  input wire logic [NUM_VARS*MEAS_W-1:0] meas_bus,  // Measured variables, signed.
  input wire logic alarm_evt,                       // Alarm condition present.
  input wire logic warn_evt,                        // Warning present.
  input wire logic [1:0] ad_out,                    // Advanced-diagnostic discrete outputs.
  input wire logic [3:0] discrete_input_block_out,  // General discrete block outputs.
  output logic switch_closed                        // High while the switch conducts.
);

  if (NUM_VARS < 1 || NUM_VARS > 15) $error("NUM_VARS must lie from 1 to 15");
  if (MEAS_W < 2 || MEAS_W > 32) $error("MEAS_W must lie from 2 to 32");

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // True when the address names a register of the block.
  function automatic logic is_mapped(input logic [sw_pkg::ADDR_W-1:0] a);
    return a == sw_pkg::ADDR_CTRL || a == sw_pkg::ADDR_ON_VAL || a == sw_pkg::ADDR_OFF_VAL ||
           a == sw_pkg::ADDR_ON_DLY || a == sw_pkg::ADDR_OFF_DLY || a == sw_pkg::ADDR_STATUS;
  endfunction

  // True when the selected kind of diagnostic event is present.
  function automatic logic diag_hit(input logic [1:0] sel, input logic al, input logic wn);
    case (sel)
      sw_pkg::DIAG_ALARM: return al;
      sw_pkg::DIAG_ALARM_WARN: return al | wn;
      sw_pkg::DIAG_WARN: return wn;
      default: return al;
    endcase
  endfunction

  // Clamps a written delay to the longest allowed delay.
  function automatic logic [sw_pkg::DLY_W-1:0] clamp_dly(input logic [31:0] v);
    return (v > 32'(sw_pkg::DLY_MAX)) ? sw_pkg::DLY_MAX : v[sw_pkg::DLY_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic signed [MEAS_W-1:0] on_val_q;
  logic signed [MEAS_W-1:0] off_val_q;
  logic [sw_pkg::DLY_W-1:0] on_dly_q;
  logic [sw_pkg::DLY_W-1:0] off_dly_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic raw_q;
  logic closed_q;

  // Carrier to the delay timer; the status word below reads its delayed state.
  dly_if #(.DLY_W(sw_pkg::DLY_W)) dl ();

  // Control fields.
  wire [2:0] func = ctrl_q[sw_pkg::FUNC_LSB +: 3];
  wire [1:0] diag_sel = ctrl_q[sw_pkg::DIAG_LSB +: 2];
  wire [2:0] src_sel = ctrl_q[sw_pkg::SRC_LSB +: 3];
  wire [3:0] var_sel = ctrl_q[sw_pkg::VAR_LSB +: 4];
  wire [1:0] fail_sel = ctrl_q[sw_pkg::FAIL_LSB +: 2];
  wire invert = ctrl_q[sw_pkg::INV_BIT];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  // The answer comes on the second access cycle; the write lands at that edge.
  wire access = psel && penable;
  wire first_acc = access && !pready_q;
  wire wr_en = access && pready_q && pwrite;
  wire mapped = is_mapped(paddr);
  wire [31:0] status_word = {27'h000_0000, alarm_evt, warn_evt, raw_q, dl.state, closed_q};
  wire [31:0] rd_word =
    (paddr == sw_pkg::ADDR_CTRL) ? ctrl_q :
    (paddr == sw_pkg::ADDR_ON_VAL) ? 32'(on_val_q) :
    (paddr == sw_pkg::ADDR_OFF_VAL) ? 32'(off_val_q) :
    (paddr == sw_pkg::ADDR_ON_DLY) ? 32'(on_dly_q) :
    (paddr == sw_pkg::ADDR_OFF_DLY) ? 32'(off_dly_q) :
    (paddr == sw_pkg::ADDR_STATUS) ? status_word : 32'h0000_0000;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Bus answer flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= first_acc;
      pslverr_q <= first_acc && !mapped;
      prdata_q <= (first_acc && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sw_pkg::CTRL_RESET;
      on_val_q <= '0;
      off_val_q <= '0;
      on_dly_q <= '0;
      off_dly_q <= '0;
    end else if (wr_en) begin
      if (paddr == sw_pkg::ADDR_CTRL) ctrl_q <= pwdata & sw_pkg::CTRL_MASK;
      if (paddr == sw_pkg::ADDR_ON_VAL) on_val_q <= pwdata[MEAS_W-1:0];
      if (paddr == sw_pkg::ADDR_OFF_VAL) off_val_q <= pwdata[MEAS_W-1:0];
      if (paddr == sw_pkg::ADDR_ON_DLY) on_dly_q <= clamp_dly(pwdata);
      if (paddr == sw_pkg::ADDR_OFF_DLY) off_dly_q <= clamp_dly(pwdata);
    end
  end

  // ----------------------------------------------------------------
  // Limit comparison
  // ----------------------------------------------------------------
  logic signed [MEAS_W-1:0] meas_arr [16];

  // Selector value 0 means no variable; unused selector values read as zero.
  for (genvar i = 0; i < 16; i++) begin : g_meas
    if (i >= 1 && i <= NUM_VARS) begin : g_used
      assign meas_arr[i] = meas_bus[(i-1)*MEAS_W +: MEAS_W];
    end else begin : g_free
      assign meas_arr[i] = '0;
    end
  end

  wire var_ok = var_sel != 4'h0 && 32'(var_sel) <= NUM_VARS;
  wire signed [MEAS_W-1:0] meas = meas_arr[var_sel];
  wire rising = on_val_q >= off_val_q;
  wire above_on = meas > on_val_q;
  wire below_on = meas < on_val_q;
  wire above_off = meas > off_val_q;
  wire below_off = meas < off_val_q;
  wire limit_on = var_ok && (func == sw_pkg::FUNC_LIMIT);

  // Hysteresis: close past the on point, open past the off point, else hold.
  wire raw_d =
    !limit_on ? 1'b0 :
    rising ? (above_on ? 1'b1 : (below_off ? 1'b0 : raw_q)) :
             (below_on ? 1'b1 : (above_off ? 1'b0 : raw_q));

  // ----------------------------------------------------------------
  // Delay timer
  // ----------------------------------------------------------------
  // Limit state and both delay settings go to the timer.
  assign dl.target = raw_q;
  assign dl.on_dly = on_dly_q;
  assign dl.off_dly = off_dly_q;

  switch_delay #(
    .STEP_CYCLES(STEP_CYCLES),
    .DLY_W(sw_pkg::DLY_W)
  ) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .dl(dl.timer)
  );

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------

  // Discrete source: none, two diagnostic blocks, four general blocks.
  wire src_val =
    (src_sel == sw_pkg::SRC_AD1) ? ad_out[0] :
    (src_sel == sw_pkg::SRC_AD2) ? ad_out[1] :
    (src_sel == sw_pkg::SRC_DO1) ? discrete_input_block_out[0] :
    (src_sel == sw_pkg::SRC_DO2) ? discrete_input_block_out[1] :
    (src_sel == sw_pkg::SRC_DO3) ? discrete_input_block_out[2] :
    (src_sel == sw_pkg::SRC_DO4) ? discrete_input_block_out[3] : 1'b0;

  wire diag_evt = diag_hit(diag_sel, alarm_evt, warn_evt);
  wire fail_apply = alarm_evt && (func == sw_pkg::FUNC_LIMIT || func == sw_pkg::FUNC_DOUT);

  // Per-function state, before failure handling and inversion.
  wire mode_state =
    (func == sw_pkg::FUNC_ON) ? 1'b1 :
    (func == sw_pkg::FUNC_DIAG) ? !diag_evt :
    (func == sw_pkg::FUNC_LIMIT) ? dl.state :
    (func == sw_pkg::FUNC_DOUT) ? src_val : 1'b0;

  // Alarm overrides in limit and discrete modes.
  wire pre_inv =
    !fail_apply ? mode_state :
    (fail_sel == sw_pkg::FAIL_OPEN) ? 1'b0 :
    (fail_sel == sw_pkg::FAIL_CLOSED) ? 1'b1 : mode_state;

  wire closed_d = pre_inv ^ invert;

  assign switch_closed = closed_q;

  // State flops of the comparison and of the final output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q <= 1'b0;
      closed_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
      closed_q <= closed_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire forced = func == sw_pkg::FUNC_OFF || func == sw_pkg::FUNC_ON;

  sequence s_status_read;
    psel && penable && !pwrite && paddr == sw_pkg::ADDR_STATUS && !pready_q;
  endsequence

  sequence s_hold_between;
    limit_on && (rising ? (!above_on && !below_off) : (!below_on && !above_off));
  endsequence

  // Alarm override to Closed in a mode that honours it, without inversion.
  sequence s_fail_closed;
    fail_apply && !invert && fail_sel == sw_pkg::FAIL_CLOSED;
  endsequence

  AST_FUNC_OFF: assert property (func == sw_pkg::FUNC_OFF && !invert |=> !switch_closed)
    else $error("Off function did not keep the output open");
  AST_FUNC_ON: assert property (func == sw_pkg::FUNC_ON && !invert |=> switch_closed)
    else $error("On function did not keep the output closed");
  AST_SIM_FORCE: assert property (forced && $stable(ctrl_q) |=> $stable(switch_closed))
    else $error("Forced output moved without a configuration change");
  AST_DIAG: assert property (func == sw_pkg::FUNC_DIAG && !invert
    |=> switch_closed == !$past(diag_evt))
    else $error("Diagnostic mode output does not match the event");
  AST_DIAG_WARN: assert property (func == sw_pkg::FUNC_DIAG && diag_sel == sw_pkg::DIAG_WARN
    && !invert && alarm_evt && !warn_evt |=> switch_closed)
    else $error("Warning-only selection opened on an alarm");
  AST_LIMIT_RISE: assert property (limit_on && rising && above_on |=> raw_q)
    else $error("Limit state not set above the on point");
  AST_LIMIT_FALL: assert property (limit_on && !rising && below_on |=> raw_q)
    else $error("Limit state not set below the on point");
  AST_HYST: assert property (s_hold_between |=> raw_q == $past(raw_q))
    else $error("Limit state changed between the thresholds");
  AST_DOUT: assert property (func == sw_pkg::FUNC_DOUT && !alarm_evt && !invert
    |=> switch_closed == $past(src_val))
    else $error("Discrete mode output does not follow its source");
  AST_FAIL: assert property (fail_apply && fail_sel == sw_pkg::FAIL_OPEN && !invert
    |=> !switch_closed)
    else $error("Failure setting Open did not open the output");
  AST_STATUS: assert property (s_status_read ##1 pready
    |-> prdata[sw_pkg::ST_CLOSED] == $past(switch_closed))
    else $error("Status read does not show the switch state");
  AST_INVERT: assert property (invert |=> switch_closed == !$past(pre_inv))
    else $error("Inversion did not swap the output state");

  // Failure, discrete source, limit release, status and bus error checks.
  AST_FAIL_CLOSED: assert property (s_fail_closed |=> switch_closed)
    else $error("Failure setting Closed did not close the output");
  AST_SRC_NONE: assert property (func == sw_pkg::FUNC_DOUT && src_sel == sw_pkg::SRC_NONE
    && !alarm_evt && !invert |=> !switch_closed)
    else $error("Discrete mode with no source did not stay open");
  AST_LIMIT_RISE_OPEN: assert property (limit_on && rising && below_off |=> !raw_q)
    else $error("Limit state not cleared below the off point");
  AST_LIMIT_FALL_OPEN: assert property (limit_on && !rising && above_off |=> !raw_q)
    else $error("Limit state not cleared above the off point");
  AST_STATUS_EVT: assert property (s_status_read ##1 pready
    |-> prdata[sw_pkg::ST_ALARM] == $past(alarm_evt) && prdata[sw_pkg::ST_WARN] == $past(warn_evt))
    else $error("Status read does not show the event inputs");
  AST_BUS_ERR: assert property (psel && penable && !pready_q && !mapped |=> pready && pslverr)
    else $error("Unmapped access did not answer with an error");

endmodule

//--- switch_load.sv
// ----------------------------------------------------------------
// External load that senses the switch contact
// ----------------------------------------------------------------
module switch_load (
  input wire logic switch_closed, // Contact state from the device.
  output logic sensed             // Load current seen by the circuit.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The load is pulled down, so an open contact reads low.
  assign sensed = switch_closed;
endmodule

//--- testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rnd = 32'h0000_04ca;
  logic pready, pslverr, switch_closed, sensed, err, alarm_evt = 0, warn_evt = 0;
  logic [63:0] meas_bus = '0;
  logic [1:0] ad_out = '0;
  logic [3:0] dq = '0;
  int err_count = 0, num_checks = 0, lim, n;
  int vals[$] = '{0, 150, 20, -80, 20, 150, 100, -50};

  // ----------------------------------------------------------------
  // Clock, design and load
  // ----------------------------------------------------------------
  always #25 pclk = ~pclk;
  switch_output_controller #(.STEP_CYCLES(4), .NUM_VARS(2), .MEAS_W(32)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_bus(meas_bus),
    .alarm_evt(alarm_evt), .warn_evt(warn_evt), .ad_out(ad_out),
    .discrete_input_block_out(dq), .switch_closed(switch_closed));
  switch_load load (.switch_closed(switch_closed), .sensed(sensed));

  // ----------------------------------------------------------------
  // Shared tasks and the reference model
  // ----------------------------------------------------------------
  // Counts a comparison and reports a difference at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (k >= 50) err_count++;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [31:0] cw(input int f, dg, sr, vr, fl, iv);
    return 32'(f | dg << 4 | sr << 8 | vr << 12 | fl << 16 | iv << 20);
  endfunction

  // Expected contact state from mode, events and the limit state.
  function automatic logic model(input int f, dg, sr, fl, iv, input logic al, wn,
                                 input logic [1:0] ad, input logic [3:0] d, input int lm);
    logic s, ev;
    ev = (dg == 2) ? wn : (dg == 1) ? (al | wn) : al;
    case (f)
      1: s = 1;
      2: s = !ev;
      3: s = lm[0];
      4: s = (sr == 1) ? ad[0] : (sr == 2) ? ad[1] : (sr >= 3 && sr <= 6) ? d[sr-3] : 1'b0;
      default: s = 0;
    endcase
    if ((f == 3 || f == 4) && al && fl == 1) s = 0;
    if ((f == 3 || f == 4) && al && fl == 2) s = 1;
    return s ^ iv[0];
  endfunction

  // Drives random events and discrete values, then compares the contact.
  task automatic ev_drive(input int f, dg, sr, fl, iv);
    rnd = xs(rnd);
    @(posedge pclk);
    alarm_evt <= rnd[0];
    warn_evt <= rnd[1];
    ad_out <= rnd[3:2];
    dq <= rnd[7:4];
    repeat (3) @(posedge pclk);
    chk(sensed, model(f, dg, sr, fl, iv, rnd[0], rnd[1], rnd[3:2], rnd[7:4], 0));
  endtask

  // Applies one measurement with zero delays and checks status and contact.
  task automatic lim_step(input int v, on, off, vr);
    @(posedge pclk);
    meas_bus[31:0] <= v;
    repeat (6) @(posedge pclk);
    if (on >= off && v > on || on < off && v < on) lim = 1;
    else if (on >= off && v < off || on < off && v > off) lim = 0;
    if (vr != 1) lim = 0;
    chk(sensed, lim);
    apb(0, sw_pkg::ADDR_STATUS, 0);
    chk(rd[2:0], {3{lim[0]}});
  endtask

  // Measures how many cycles the contact takes to reach a level.
  task automatic dly_meas(input int v, input logic lv, input int d);
    @(posedge pclk);
    meas_bus[31:0] <= v;
    n = 0;
    while (sensed !== lv && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= d + 2 && n <= d + 6, 1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, sw_pkg::ADDR_CTRL, 0);
    chk(rd, sw_pkg::CTRL_RESET);
    chk(sensed, 0);
    apb(1, sw_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    apb(0, sw_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h0013_F737);
    apb(1, sw_pkg::ADDR_ON_DLY, 32'h0000_FFFF);
    apb(0, sw_pkg::ADDR_ON_DLY, 0);
    chk(rd, 32'h0000_03E8);
    apb(0, 12'h018, 0);
    chk({rd[30:0], err}, 32'h0000_0001);
    $display("test registers done");
    for (int f = 0; f < 3; f++)
      for (int iv = 0; iv < 2; iv++)
        for (int dg = 0; dg < 4; dg++) begin
          apb(1, sw_pkg::ADDR_CTRL, cw(f, dg, 0, 0, 1 + iv, iv));
          repeat (4) ev_drive(f, dg, 0, 1 + iv, iv);
        end
    $display("test forced and diagnostic done");
    for (int sr = 0; sr < 8; sr++)
      for (int fl = 0; fl < 4; fl++) begin
        apb(1, sw_pkg::ADDR_CTRL, cw(4, 0, sr, 0, fl, sr % 2));
        repeat (3) ev_drive(4, 0, sr, fl, sr % 2);
      end
    $display("test discrete done");
    alarm_evt <= 0;
    warn_evt <= 0;
    apb(1, sw_pkg::ADDR_ON_DLY, 0);
    for (int c = 0; c < 4; c++) begin
      lim = 0;
      apb(1, sw_pkg::ADDR_CTRL, cw(3, 0, 0, 3, 0, 0));
      apb(1, sw_pkg::ADDR_ON_VAL, c[0] ? -50 : 100);
      apb(1, sw_pkg::ADDR_OFF_VAL, c[0] ? 100 : -50);
      apb(1, sw_pkg::ADDR_CTRL, cw(3, 0, 0, c[1] ? 3 : 1, 0, 0));
      foreach (vals[i]) lim_step(vals[i], c[0] ? -50 : 100, c[0] ? 100 : -50, c[1] ? 3 : 1);
    end
    $display("test limit done");
    apb(1, sw_pkg::ADDR_ON_VAL, 100);
    apb(1, sw_pkg::ADDR_OFF_VAL, -50);
    apb(1, sw_pkg::ADDR_ON_DLY, 2);
    apb(1, sw_pkg::ADDR_OFF_DLY, 3);
    apb(1, sw_pkg::ADDR_CTRL, cw(3, 0, 0, 1, 0, 0));
    dly_meas(150, 1, 8);
    dly_meas(-80, 0, 12);
    @(posedge pclk);
    meas_bus[31:0] <= 150;
    repeat (4) @(posedge pclk);
    meas_bus[31:0] <= -80;
    repeat (20) @(posedge pclk);
    chk(sensed, 0);
    $display("test delays done");
    tally_and_finish;
  end

  // Cuts a hang short well after the expected run time.
  initial begin
    #1_000_000;
    err_count++;
    tally_and_finish;
  end
endmodule
